// ===== logic/iaf_defs.svh
`ifndef IAF_DEFS_SVH
`define IAF_DEFS_SVH
// Contract
// - Maskable requests blocked while mask flag is 0, considered at 1.
// - Acknowledging a request clears the mask flag to 0.
// - Stack flag 0 selects interrupt stack pointer, 1 user stack pointer.
// - Stack flag clears on hardware acknowledge and on traps 0 through 31.
// - Priority level field is 3 bits, levels 0 through 7.
// - Accept only above the current level; others stay pending.

// ---------------------------------------------------------------
// Field widths
// ---------------------------------------------------------------
`define IAF_LVL_W 3
`define IAF_VEC_W 6

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define IAF_RST_MASK 1'h0
`define IAF_RST_STACK 1'h0
`define IAF_RST_LVL 3'h0
`define IAF_TRAP_LAST 6'h1F
`endif

// ===== logic/iaf_flags.sv
`timescale 1ns/1ps
`include "iaf_defs.svh"
module iaf_flags (
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Peripheral request side
   input wire logic irq_req_i,
   input wire logic [`IAF_LVL_W-1:0] irq_level_i,
   // Sequencer operation side
   input wire iaf_pkg::iaf_op_t seq_op_i,
   input wire iaf_pkg::iaf_flag_wr_t seq_wdata_i,
   input wire logic [`IAF_VEC_W-1:0] seq_vec_i,
   input wire iaf_pkg::iaf_flags_t seq_restore_i,
   // Flags, saved copy, stack select and acknowledge outputs
   output iaf_pkg::iaf_flags_t flags_o,
   output iaf_pkg::iaf_flags_t saved_o,
   output logic stack_user_o,
   output logic irq_ack_o,
   output logic [`IAF_LVL_W-1:0] ack_level_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   iaf_pkg::iaf_state_t state;
   iaf_pkg::iaf_state_t next_state;
   iaf_pkg::iaf_flags_t flags;
   iaf_pkg::iaf_flags_t next_flags;
   iaf_pkg::iaf_flags_t saved;
   iaf_pkg::iaf_flags_t next_saved;
   logic stack_user;
   logic next_stack_user;
   logic ack;
   logic next_ack;
   logic [`IAF_LVL_W-1:0] ack_level;
   logic [`IAF_LVL_W-1:0] next_ack_level;
   logic accept;

   // Priority compare, used by acceptance and by the checks
   function automatic logic above_level(
      input logic [`IAF_LVL_W-1:0] req,
      input logic [`IAF_LVL_W-1:0] cur
   );
      above_level = (req > cur);
   endfunction : above_level

   // Trap vectors in the low range also switch to the interrupt stack
   function automatic logic low_trap(input logic [`IAF_VEC_W-1:0] vec);
      low_trap = (vec <= `IAF_TRAP_LAST);
   endfunction : low_trap

   // ---------------------------------------------------------------
   // Acceptance
   // ---------------------------------------------------------------
   // Requests are taken only between sequencer operations, so an
   // instruction that rewrites the flags always finishes first.
   // A request at or below the level is not consumed and stays pending.
   always_comb begin
      accept = (state == iaf_pkg::IAF_ST_RUN) &&
               (seq_op_i == iaf_pkg::IAF_OP_NONE) &&
               irq_req_i &&
               flags.mask_en &&
               above_level(irq_level_i,
                           flags.processor_priority_level);
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // One acknowledge cycle follows each acceptance; sequencer
   // operations offered during it are ignored.
   always_comb begin
      next_state = state;
      next_flags = flags;
      next_saved = saved;
      next_ack = 1'b0;
      next_ack_level = ack_level;
      case (state)
         iaf_pkg::IAF_ST_RUN: begin
            if (accept) begin
               next_saved = flags;
               next_flags.mask_en = 1'b0;
               next_flags.stack_user = 1'b0;
               next_flags.processor_priority_level = irq_level_i;
               next_ack = 1'b1;
               next_ack_level = irq_level_i;
               next_state = iaf_pkg::IAF_ST_ACK;
            end else begin
               case (seq_op_i)
                  iaf_pkg::IAF_OP_WRITE: begin
                     // Reserved bit is dropped; it is never stored
                     next_flags = seq_wdata_i.flags;
                  end
                  iaf_pkg::IAF_OP_TRAP: begin
                     next_saved = flags;
                     if (low_trap(seq_vec_i)) begin
                        next_flags.stack_user = 1'b0;
                     end
                  end
                  iaf_pkg::IAF_OP_RETURN: begin
                     next_flags = seq_restore_i;
                  end
                  default: begin
                     next_flags = flags;
                  end
               endcase
            end
         end
         iaf_pkg::IAF_ST_ACK: begin
            next_state = iaf_pkg::IAF_ST_RUN;
         end
         default: begin
            next_state = iaf_pkg::IAF_ST_RUN;
         end
      endcase
      // Stack choice follows the stack flag directly
      next_stack_user = next_flags.stack_user;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Clock enable low freezes every bit, acknowledge included.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= iaf_pkg::IAF_ST_RUN;
         flags.mask_en <= `IAF_RST_MASK;
         flags.stack_user <= `IAF_RST_STACK;
         flags.processor_priority_level <= `IAF_RST_LVL;
         saved <= '0;
         stack_user <= `IAF_RST_STACK;
         ack <= 1'b0;
         ack_level <= `IAF_RST_LVL;
      end else if (ce_i) begin
         state <= next_state;
         flags <= next_flags;
         saved <= next_saved;
         stack_user <= next_stack_user;
         ack <= next_ack;
         ack_level <= next_ack_level;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // All outputs are the registers themselves
   assign flags_o = flags;
   assign saved_o = saved;
   assign stack_user_o = stack_user;
   assign irq_ack_o = ack;
   assign ack_level_o = ack_level;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   // A masked core never acknowledges on the next edge
   property p_mask_blocks;
      (ce_i && state == iaf_pkg::IAF_ST_RUN && !flags.mask_en)
         |=> !ack;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("acknowledge while mask flag was 0");

   // Acknowledge comes with the mask and stack flags cleared
   property p_ack_clears;
      ack |-> (!flags.mask_en && !flags.stack_user);
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("flags not cleared on acknowledge");

   // Stack select output follows the flag
   property p_stack_sel;
      stack_user == flags.stack_user;
   endproperty
   a_stack_sel: assert property (p_stack_sel)
      else $error("stack select disagrees with flag");

   // Low-range trap switches to the interrupt stack
   property p_trap_low;
      (ce_i && state == iaf_pkg::IAF_ST_RUN &&
       seq_op_i == iaf_pkg::IAF_OP_TRAP && low_trap(seq_vec_i))
         |=> !stack_user;
   endproperty
   a_trap_low: assert property (p_trap_low)
      else $error("low trap left user stack selected");

   // High-range trap keeps the stack flag
   property p_trap_high;
      (ce_i && state == iaf_pkg::IAF_ST_RUN &&
       seq_op_i == iaf_pkg::IAF_OP_TRAP && !low_trap(seq_vec_i))
         |=> (stack_user == $past(flags.stack_user));
   endproperty
   a_trap_high: assert property (p_trap_high)
      else $error("high trap changed stack flag");

   // Accepted level becomes the new processor level
   property p_level_load;
      ack |-> (flags.processor_priority_level == ack_level);
   endproperty
   a_level_load: assert property (p_level_load)
      else $error("level not loaded on acknowledge");

   // Only strictly higher requests are acknowledged
   property p_strict;
      ack |-> above_level(ack_level, saved.processor_priority_level);
   endproperty
   a_strict: assert property (p_strict)
      else $error("acknowledged request not above level");

   // Saved copy holds the unmasked pre-acknowledge flags; checked on the
   // first acknowledge cycle only, since a frozen clock enable can stretch
   // the pulse and the older flags would then already be the cleared ones
   property p_saved;
      $rose(ack) |-> (saved.mask_en && saved == $past(flags));
   endproperty
   a_saved: assert property (p_saved)
      else $error("saved flags wrong on acknowledge");

   // Main scenarios
   c_accept: cover property (ack);
   c_trap_low: cover property (ce_i && seq_op_i == iaf_pkg::IAF_OP_TRAP
                               && low_trap(seq_vec_i));
   c_pending: cover property (irq_req_i && flags.mask_en &&
      !above_level(irq_level_i, flags.processor_priority_level));
   c_return: cover property (ce_i && seq_op_i == iaf_pkg::IAF_OP_RETURN);

endmodule : iaf_flags

// ===== logic/iaf_pkg.sv
`include "iaf_defs.svh"
package iaf_pkg;
   // Flag group carried between core and this block
   typedef struct packed {
      logic mask_en;
      logic stack_user;
      logic [`IAF_LVL_W-1:0] processor_priority_level;
   } iaf_flags_t;

   // Flag register write as software presents it
   typedef struct packed {
      logic rsvd;
      iaf_flags_t flags;
   } iaf_flag_wr_t;

   // Sequencer operations
   typedef enum logic [1:0] {
      IAF_OP_NONE = 2'b00,
      IAF_OP_WRITE = 2'b01,
      IAF_OP_TRAP = 2'b10,
      IAF_OP_RETURN = 2'b11
   } iaf_op_t;

   // Acknowledge sequencing
   typedef enum logic {
      IAF_ST_RUN = 1'b0,
      IAF_ST_ACK = 1'b1
   } iaf_state_t;
endpackage : iaf_pkg

// ===== tb/iaf_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Peripheral request source model
// ---------------------------------------------------------------
module iaf_src (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Bench control and acknowledge from the block
   input wire logic want_i,
   input wire logic [2:0] lvl_i,
   input wire logic ack_i,
   // Request toward the block
   output logic req_o,
   output logic [2:0] level_o
);
   logic done;
   logic next_req;
   // Request is held until acknowledged, then dropped until want_i is released
   always_comb begin
      next_req = want_i && !done && !ack_i;
   end
   // Idle level inverts itself every cycle so a stale value is never read
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         req_o <= 1'h0;
         done <= 1'h0;
         level_o <= 3'h0;
      end else begin
         req_o <= next_req;
         done <= want_i && (done || ack_i);
         level_o <= next_req ? lvl_i : ~level_o;
      end
   end
endmodule : iaf_src

// ===== tb/interrupt_acceptance_flags_bench.sv
`timescale 1ns/1ps
module interrupt_acceptance_flags_bench;
   logic mclk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic ce_i = 1'h1;
   logic want = 1'h0;
   logic [2:0] lvl = 3'h0;
   logic irq_req_i;
   logic [2:0] irq_level_i;
   iaf_pkg::iaf_op_t seq_op_i = iaf_pkg::IAF_OP_NONE;
   iaf_pkg::iaf_flag_wr_t seq_wdata_i = 6'h00;
   logic [5:0] seq_vec_i = 6'h00;
   iaf_pkg::iaf_flags_t seq_restore_i = 5'h00;
   iaf_pkg::iaf_flags_t flags_o;
   iaf_pkg::iaf_flags_t saved_o;
   logic stack_user_o;
   logic irq_ack_o;
   logic [2:0] ack_level_o;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int cnt;

   iaf_flags uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
      .seq_op_i(seq_op_i), .seq_wdata_i(seq_wdata_i),
      .seq_vec_i(seq_vec_i), .seq_restore_i(seq_restore_i),
      .flags_o(flags_o), .saved_o(saved_o), .stack_user_o(stack_user_o),
      .irq_ack_o(irq_ack_o), .ack_level_o(ack_level_o));
   iaf_src src (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .want_i(want),
      .lvl_i(lvl), .ack_i(irq_ack_o), .req_o(irq_req_i),
      .level_o(irq_level_i));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One sequencer op, sampled after the edge that takes it
   task automatic op(input iaf_pkg::iaf_op_t o, input logic [5:0] d);
      @(posedge mclk_i);
      seq_op_i <= o;
      seq_wdata_i <= d;
      seq_vec_i <= d;
      seq_restore_i <= d[4:0];
      @(posedge mclk_i);
      seq_op_i <= iaf_pkg::IAF_OP_NONE;
      #1;
   endtask : op

   // Raise a request, count acknowledge pulses over a bounded wait
   task automatic ask(input logic [2:0] l);
      cnt = 0;
      @(posedge mclk_i);
      want <= 1'h1;
      lvl <= l;
      repeat (6) begin
         @(posedge mclk_i);
         #1;
         if (irq_ack_o === 1'h1) cnt++;
      end
      @(posedge mclk_i);
      want <= 1'h0;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : ask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_mask;
      chk({3'h0, flags_o}, 8'h00);
      chk({3'h0, saved_o}, 8'h00);
      ask(3'h7);
      chk(cnt[7:0], 8'h00);
      $display("test mask done");
   endtask : t_mask

   // Frozen by clock enable, then level compare and acknowledge
   task automatic t_level;
      op(iaf_pkg::IAF_OP_WRITE, 6'h1B);
      chk({3'h0, flags_o}, 8'h1B);
      chk({7'h00, stack_user_o}, 8'h01);
      @(posedge mclk_i);
      ce_i <= 1'h0;
      op(iaf_pkg::IAF_OP_WRITE, 6'h00);
      @(posedge mclk_i);
      ce_i <= 1'h1;
      #1;
      chk({3'h0, flags_o}, 8'h1B);
      ask(3'h3);
      chk(cnt[7:0], 8'h00);
      ask(3'h4);
      chk(cnt[7:0], 8'h01);
      chk({3'h0, flags_o}, 8'h04);
      chk({3'h0, saved_o}, 8'h1B);
      chk({7'h00, stack_user_o}, 8'h00);
      chk({5'h00, ack_level_o}, 8'h04);
      $display("test level done");
   endtask : t_level

   // Trap vector boundary, then return to the top level
   task automatic t_trap;
      op(iaf_pkg::IAF_OP_WRITE, 6'h1A);
      op(iaf_pkg::IAF_OP_TRAP, 6'h20);
      chk({3'h0, flags_o}, 8'h1A);
      op(iaf_pkg::IAF_OP_TRAP, 6'h1F);
      chk({3'h0, flags_o}, 8'h12);
      chk({3'h0, saved_o}, 8'h1A);
      op(iaf_pkg::IAF_OP_RETURN, 6'h1F);
      chk({3'h0, flags_o}, 8'h1F);
      ask(3'h7);
      chk(cnt[7:0], 8'h00);
      $display("test trap done");
   endtask : t_trap

   // ---------------------------------------------------------------
   // Clock, reset, timeout and main sequence
   // ---------------------------------------------------------------
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   // Whole run is well under this ceiling
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge mclk_i);
      sys_rst_i <= 1'h0;
      @(posedge mclk_i);
      #1;
      t_mask();
      t_level();
      t_trap();
      final_report();
   end
endmodule : interrupt_acceptance_flags_bench
